// ==== bsc_pkg.sv ====
// Types shared by the sync channel block.
// Assumes the constants header is compiled alongside.
package bsc_pkg;
  typedef enum logic [1:0] {
    BSC_TX_IDLE = 2'b00,
    BSC_TX_SEND = 2'b01,
    BSC_TX_FILL = 2'b11
  } bsc_tx_state_type;
  typedef enum logic [1:0] {
    BSC_RX_HUNT = 2'b00,
    BSC_RX_SYNC = 2'b01
  } bsc_rx_state_type;
endpackage

// ==== bsc_regs.svh ====
// Register offsets, field positions, reset values and timing counts of the sync channel block.
// Assumes an 8-bit register port with byte offsets; included by bsc_top.sv and the testbench, not by bsc_pkg.sv.
`ifndef BSC_REGS_SVH
`define BSC_REGS_SVH
`define BSC_OFS_MODE     8'h02
`define BSC_OFS_TIMER    8'h03
`define BSC_OFS_SYNC_CHAR_LOW     8'h04
`define BSC_OFS_SYNC_CHAR_HIGH     8'h05
`define BSC_OFS_TERM     8'h06
`define BSC_OFS_FMT      8'h07
`define BSC_OFS_RFC      8'h08
`define BSC_OFS_CMD      8'h20
`define BSC_OFS_RECEIVE_BYTE_COUNT_LOW     8'h2A
`define BSC_OFS_TRANSMIT_BYTE_COUNT_LOW     8'h2A
`define BSC_OFS_TRANSMIT_COUNT_HIGH     8'h2B
`define BSC_OFS_STAT     8'h09
`define BSC_RST_BYTE     8'h00
`define BSC_MODE_RTS     2
`define BSC_MODE_TRS     1
`define BSC_MODE_TLP     0
`define BSC_MODE_SYNC_LENGTH_SELECT    4
`define BSC_MODE_DSYN    5
`define BSC_MODE_ITF     6
`define BSC_FMT_PARITY_ENABLE     2
`define BSC_RFC_DPS      6
`define BSC_RFC_SYNC_STORE_ENABLE    5
`define BSC_RFC_STATUS_BYTE_ENABLE     4
`define BSC_RFC_END_CHAR_DETECT_ENABLE     2
`define BSC_TRANSMIT_COUNT_HIGH_DMA     7
`define BSC_CMD_RMC      7
`define BSC_CMD_STI      4
`define BSC_CMD_XF       3
`define BSC_CMD_HUNT     2
`define BSC_K_LONG       32768
`define BSC_K_SHORT      512
`define BSC_REPEAT_ALL   3'h7
`endif

// ==== bsc_station.sv ====
// Remote synchronous station: drives the receive serial line and its bit tick.
// Assumes the bench clock; bits go out LSB first, one tick per bit.
`timescale 1ns/100ps
module bsc_station (
  input  wire logic clk,
  output logic      rx_in,
  output logic      rx_bit_tick
);
  // Mark idle on the line before any frame
  initial begin
    rx_in       = 1'b1;
    rx_bit_tick = 1'b0;
  end

  // Send n bits of v, LSB first, with gap idle cycles after each bit
  task automatic send(input logic [7:0] v, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rx_in       <= v[i];
      rx_bit_tick <= 1'b1;
      @(posedge clk);
      rx_bit_tick <= 1'b0;
      if (i == n - 1) begin
        rx_in <= 1'b1;
      end
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule // bsc_station

// ==== bsc_top.sv ====
// Channel control for a character-oriented synchronous serial channel: registers, timer,
// SYN fill/hunt, end-character detection, receive format, byte counts and DMA requests.
// Assumes one 50 MHz clock, one transmit bit per tx_bit_tick, and a byte-wide register port.
`timescale 1ns/100ps
`include "bsc_regs.svh"

module bsc_top #(
  parameter int unsigned K_LONG  = `BSC_K_LONG,
  parameter int unsigned K_SHORT = `BSC_K_SHORT
) (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       tx_bit_tick,
  input  wire logic       tx_have_data,
  input  wire logic       tx_data_bit,
  output logic            tx_out,
  output logic            tx_busy,
  input  wire logic       rx_in,
  input  wire logic       rx_bit_tick,
  output logic            rts_out,
  output logic            rx_wr_valid,
  output logic      [7:0] rx_wr_data,
  output logic            timer_irq,
  output logic            end_char_detected_irq,
  output logic            receive_pool_full_irq,
  output logic            parity_error_irq,
  output logic            dma_tx_req
);
  logic [7:0] mode_q, interval_timer_q, sync_pattern_low_q, sync_pattern_high_q;
  logic [7:0] end_char_register_q, character_format_q, receive_queue_control_q;
  logic [4:0] transmit_count_high_q;
  logic [7:0] transmit_count_low_q;
  logic [7:0] receive_counter_q;
  logic       wr_cmd, rmc_cmd, sti_cmd, xf_cmd, hunt_cmd;
  logic       end_seen_q;

  assign wr_cmd   = reg_write && (reg_addr == `BSC_OFS_CMD);
  assign rmc_cmd  = wr_cmd && reg_wdata[`BSC_CMD_RMC];
  assign sti_cmd  = wr_cmd && reg_wdata[`BSC_CMD_STI];
  assign xf_cmd   = wr_cmd && reg_wdata[`BSC_CMD_XF];
  assign hunt_cmd = wr_cmd && reg_wdata[`BSC_CMD_HUNT];

  // Character length in bits from the two-bit field
  function automatic logic [3:0] char_bits(input logic [1:0] code);
    char_bits = 4'h8 - {2'b00, code};
  endfunction

  // Threshold in bytes from code and status format
  function automatic logic [5:0] thresh_bytes(input logic [1:0] code, input logic sts);
    unique case (code)
      2'b00:   thresh_bytes = sts ? 6'h02 : 6'h01;
      2'b01:   thresh_bytes = 6'h04;
      2'b10:   thresh_bytes = 6'h10;
      default: thresh_bytes = 6'h20;
    endcase
  endfunction

  // Configuration register writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_q                  <= `BSC_RST_BYTE;
      interval_timer_q        <= `BSC_RST_BYTE;
      sync_pattern_low_q      <= `BSC_RST_BYTE;
      sync_pattern_high_q     <= `BSC_RST_BYTE;
      end_char_register_q     <= `BSC_RST_BYTE;
      character_format_q      <= `BSC_RST_BYTE;
      receive_queue_control_q <= `BSC_RST_BYTE;
      transmit_count_low_q    <= `BSC_RST_BYTE;
      transmit_count_high_q   <= 5'h00;
    end else if (reg_write) begin
      unique case (reg_addr)
        `BSC_OFS_MODE:  mode_q                  <= reg_wdata;
        `BSC_OFS_TIMER: interval_timer_q        <= reg_wdata;
        `BSC_OFS_SYNC_CHAR_LOW:  sync_pattern_low_q      <= reg_wdata;
        `BSC_OFS_SYNC_CHAR_HIGH:  sync_pattern_high_q     <= reg_wdata;
        `BSC_OFS_TERM:  end_char_register_q     <= reg_wdata;
        `BSC_OFS_FMT:   character_format_q      <= reg_wdata;
        `BSC_OFS_RFC:   receive_queue_control_q <= reg_wdata;
        `BSC_OFS_TRANSMIT_BYTE_COUNT_LOW:  transmit_count_low_q    <= reg_wdata;
        `BSC_OFS_TRANSMIT_COUNT_HIGH:  transmit_count_high_q   <= {reg_wdata[`BSC_TRANSMIT_COUNT_HIGH_DMA], reg_wdata[3:0]};
        default: ;
      endcase
    end
  end

  // Read port, data in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      unique case (reg_addr)
        `BSC_OFS_MODE:  reg_rdata <= mode_q;
        `BSC_OFS_TIMER: reg_rdata <= interval_timer_q;
        `BSC_OFS_SYNC_CHAR_LOW:  reg_rdata <= sync_pattern_low_q;
        `BSC_OFS_SYNC_CHAR_HIGH:  reg_rdata <= sync_pattern_high_q;
        `BSC_OFS_TERM:  reg_rdata <= end_char_register_q;
        `BSC_OFS_FMT:   reg_rdata <= character_format_q;
        `BSC_OFS_RFC:   reg_rdata <= receive_queue_control_q;
        `BSC_OFS_RECEIVE_BYTE_COUNT_LOW:  reg_rdata <= receive_counter_q;
        `BSC_OFS_STAT:  reg_rdata <= {5'h00, tx_busy, rts_out, end_seen_q};
        default:        reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Interval timer: prescale by k per bit tick, then count loops, then t1 periods
  logic [15:0] pre_q;
  logic [4:0]  val_q;
  logic [7:0]  loop_q;
  logic        run_q;
  logic [15:0] k_last;
  logic [7:0]  loops_total;
  assign k_last      = mode_q[`BSC_MODE_TRS] ? 16'(K_SHORT - 1) : 16'(K_LONG - 1);
  assign loops_total = {interval_timer_q[7:5], 5'h00};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pre_q     <= 16'h0000;
      val_q     <= 5'h00;
      loop_q    <= 8'h00;
      run_q     <= 1'b0;
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= 1'b0;
      if (reg_write && reg_addr == `BSC_OFS_TIMER) begin
        run_q <= 1'b0;
      end else if (sti_cmd) begin
        run_q  <= 1'b1;
        pre_q  <= 16'h0000;
        val_q  <= 5'h00;
        loop_q <= 8'h00;
      end else if (run_q && tx_bit_tick) begin
        if (pre_q != k_last) begin
          pre_q <= pre_q + 16'h0001;
        end else begin
          pre_q <= 16'h0000;
          if (loop_q != loops_total || interval_timer_q[7:5] == `BSC_REPEAT_ALL) begin
            loop_q <= loop_q + 8'h01;
          end else if (val_q != interval_timer_q[4:0]) begin
            val_q <= val_q + 5'h01;
          end else begin
            timer_irq <= 1'b1;
            val_q     <= 5'h00;
            run_q     <= 1'b0;
          end
          if (interval_timer_q[7:5] == `BSC_REPEAT_ALL) begin
            loop_q <= 8'h00;
            if (val_q != interval_timer_q[4:0]) begin
              val_q <= val_q + 5'h01;
            end else begin
              val_q     <= 5'h00;
              timer_irq <= 1'b1;
            end
          end
        end
      end
    end
  end

  // SYN pattern assembly and bit count
  logic [15:0] syn_pat;
  logic [4:0]  syn_len;
  always_comb begin
    syn_pat = 16'h0000;
    syn_len = 5'h00;
    if (!mode_q[`BSC_MODE_DSYN]) begin
      syn_pat = mode_q[`BSC_MODE_SYNC_LENGTH_SELECT] ? {8'h00, sync_pattern_low_q}
                                       : {10'h000, sync_pattern_low_q[5:0]};
      syn_len = mode_q[`BSC_MODE_SYNC_LENGTH_SELECT] ? 5'd8 : 5'd6;
    end else if (mode_q[`BSC_MODE_SYNC_LENGTH_SELECT]) begin
      syn_pat = {sync_pattern_high_q, sync_pattern_low_q};
      syn_len = 5'd16;
    end else begin
      syn_pat = {4'h0, sync_pattern_high_q[5:0], sync_pattern_low_q[5:0]};
      syn_len = 5'd12;
    end
  end

  // Transmitter: data, SYN fill or marking idle; DMA block request count
  bsc_pkg::bsc_tx_state_type tx_q;
  logic [4:0]  tx_pos_q;
  logic [12:0] dma_left_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_q       <= bsc_pkg::BSC_TX_IDLE;
      tx_pos_q   <= 5'h00;
      tx_out     <= 1'b1;
      tx_busy    <= 1'b0;
      dma_left_q <= 13'h0000;
      dma_tx_req <= 1'b0;
    end else begin
      if (xf_cmd && transmit_count_high_q[4]) begin
        dma_left_q <= {1'b0, transmit_count_high_q[3:0], transmit_count_low_q} + 13'h0001;
      end else if (dma_tx_req) begin
        dma_left_q <= dma_left_q - 13'h0001;
      end
      dma_tx_req <= (dma_left_q > 13'h0001) || (dma_left_q == 13'h0001 && !dma_tx_req);
      if (tx_bit_tick) begin
        unique case (tx_q)
          bsc_pkg::BSC_TX_IDLE, bsc_pkg::BSC_TX_FILL: begin
            tx_busy <= tx_have_data;
            if (tx_have_data && tx_pos_q == 5'h00) begin
              tx_q   <= bsc_pkg::BSC_TX_SEND;
              tx_out <= tx_data_bit;
            end else if (mode_q[`BSC_MODE_ITF]) begin
              tx_q     <= bsc_pkg::BSC_TX_FILL;
              tx_out   <= syn_pat[tx_pos_q[3:0]];
              tx_pos_q <= (tx_pos_q + 5'h01 == syn_len) ? 5'h00 : tx_pos_q + 5'h01;
            end else begin
              tx_q   <= bsc_pkg::BSC_TX_IDLE;
              tx_out <= 1'b1;
            end
          end
          bsc_pkg::BSC_TX_SEND: begin
            tx_out  <= tx_have_data ? tx_data_bit : 1'b1;
            tx_busy <= tx_have_data;
            if (!tx_have_data) begin
              tx_q <= bsc_pkg::BSC_TX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // RTS: forced by control bit, else follows transmit activity
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rts_out <= 1'b0;
    end else begin
      rts_out <= mode_q[`BSC_MODE_RTS] | tx_busy;
    end
  end

  // Receiver: loop select, hunt shift register, character assembly
  bsc_pkg::bsc_rx_state_type rx_q;
  logic        rx_bit;
  logic [15:0] hunt_sr_q;
  logic [15:0] hunt_mask;
  logic [8:0]  ch_q;
  logic [3:0]  cnt_q;
  logic [3:0]  ch_bits;
  logic        par_on;
  assign rx_bit    = mode_q[`BSC_MODE_TLP] ? tx_out : rx_in;
  assign hunt_mask = 16'hFFFF >> (5'd16 - syn_len);
  assign ch_bits   = char_bits(character_format_q[1:0]);
  assign par_on    = character_format_q[`BSC_FMT_PARITY_ENABLE];

  // Received character fields, LSB first into a right-justified word
  logic [7:0] data_c;
  logic       par_c;
  logic       perr_c;
  logic       is_syn_c;
  logic [8:0] ch_next;
  always_comb begin
    ch_next  = {rx_bit, ch_q[8:1]};
    data_c   = 8'(ch_next >> (4'd9 - ch_bits - {3'h0, par_on}));
    data_c   = data_c & (8'hFF >> (4'd8 - ch_bits));
    par_c    = ch_next[8];
    unique case (character_format_q[4:3])
      2'b00:   perr_c = par_c != 1'b0;
      2'b01:   perr_c = par_c == ^data_c;
      2'b10:   perr_c = par_c != ^data_c;
      default: perr_c = par_c != 1'b1;
    endcase
    perr_c   = perr_c & par_on;
    is_syn_c = data_c == sync_pattern_low_q;
  end

  logic       pend_sts_q;
  logic [7:0] sts_q;
  logic [5:0] fill_q;
  logic       stored;
  assign stored = rx_wr_valid && !pend_sts_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_q             <= bsc_pkg::BSC_RX_HUNT;
      hunt_sr_q        <= 16'h0000;
      ch_q             <= 9'h000;
      cnt_q            <= 4'h0;
      rx_wr_valid      <= 1'b0;
      rx_wr_data       <= 8'h00;
      pend_sts_q       <= 1'b0;
      sts_q            <= 8'h00;
      parity_error_irq <= 1'b0;
      end_char_detected_irq <= 1'b0;
    end else begin
      rx_wr_valid           <= 1'b0;
      parity_error_irq      <= 1'b0;
      end_char_detected_irq <= 1'b0;
      if (pend_sts_q) begin
        rx_wr_valid <= 1'b1;
        rx_wr_data  <= sts_q;
        pend_sts_q  <= 1'b0;
      end
      if (hunt_cmd) begin
        rx_q <= bsc_pkg::BSC_RX_HUNT;
      end else if (rx_bit_tick) begin
        hunt_sr_q <= {rx_bit, hunt_sr_q[15:1]};
        if (rx_q == bsc_pkg::BSC_RX_HUNT) begin
          if (((({rx_bit, hunt_sr_q[15:1]}) >> (5'd16 - syn_len)) & hunt_mask) == syn_pat) begin
            rx_q  <= bsc_pkg::BSC_RX_SYNC;
            cnt_q <= 4'h0;
          end
        end else begin
          ch_q <= ch_next;
          if (cnt_q + 4'h1 == ch_bits + {3'h0, par_on}) begin
            cnt_q <= 4'h0;
            if (!is_syn_c || receive_queue_control_q[`BSC_RFC_SYNC_STORE_ENABLE]) begin
              rx_wr_valid <= 1'b1;
              rx_wr_data  <= data_c;
              if (par_on && ch_bits != 4'h8 && !receive_queue_control_q[`BSC_RFC_DPS]) begin
                rx_wr_data <= data_c | (8'({par_c}) << ch_bits);
              end
              pend_sts_q       <= receive_queue_control_q[`BSC_RFC_STATUS_BYTE_ENABLE];
              sts_q            <= {perr_c, 6'h00, par_c};
              parity_error_irq <= perr_c;
              if (receive_queue_control_q[`BSC_RFC_END_CHAR_DETECT_ENABLE] && data_c == end_char_register_q) begin
                end_char_detected_irq <= 1'b1;
              end
            end
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
      end
    end
  end

  // Pool fill, pool-full event, byte counter and end latch
  logic [5:0] th;
  assign th = thresh_bytes(receive_queue_control_q[1:0], receive_queue_control_q[`BSC_RFC_STATUS_BYTE_ENABLE]);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fill_q                <= 6'h00;
      receive_counter_q     <= 8'h00;
      end_seen_q            <= 1'b0;
      receive_pool_full_irq <= 1'b0;
    end else begin
      receive_pool_full_irq <= 1'b0;
      if (rx_wr_valid) begin
        if (fill_q + 6'h01 == th) begin
          fill_q                <= 6'h00;
          receive_pool_full_irq <= 1'b1;
          receive_counter_q     <= receive_counter_q + {2'b00, th};
        end else begin
          fill_q <= fill_q + 6'h01;
        end
      end
      if (end_char_detected_irq) begin
        end_seen_q        <= 1'b1;
        receive_counter_q <= receive_counter_q + {2'b00, fill_q} + 8'h01;
      end else if (rmc_cmd && end_seen_q) begin
        end_seen_q        <= 1'b0;
        receive_counter_q <= 8'h00;
        fill_q            <= 6'h00;
      end
    end
  end

  // Checks on outputs and internal registers
  a_rts_forced: assert property (@(posedge clk) disable iff (!resetn)
    mode_q[`BSC_MODE_RTS] |=> rts_out) else $error("rts not forced");
  a_loop_route: assert property (@(posedge clk) disable iff (!resetn)
    mode_q[`BSC_MODE_TLP] && rx_bit_tick && !hunt_cmd |=> hunt_sr_q[15] == $past(tx_out))
    else $error("loop not routed");
  a_rts_idle: assert property (@(posedge clk) disable iff (!resetn)
    !mode_q[`BSC_MODE_RTS] && !tx_busy |=> !rts_out) else $error("rts stuck");
  a_count_clear: assert property (@(posedge clk) disable iff (!resetn)
    rmc_cmd && end_seen_q && !end_char_detected_irq |=> receive_counter_q == 8'h00)
    else $error("count not cleared");
  a_status_after: assert property (@(posedge clk) disable iff (!resetn)
    pend_sts_q |=> rx_wr_valid && rx_wr_data == $past(sts_q)) else $error("status missing");
  a_pool_inc: assert property (@(posedge clk) disable iff (!resetn)
    rx_wr_valid && fill_q + 6'h01 == th && !end_char_detected_irq
    |=> receive_counter_q == $past(receive_counter_q) + {2'b00, $past(th)})
    else $error("pool count wrong");
  a_pool_irq: assert property (@(posedge clk) disable iff (!resetn)
    receive_pool_full_irq |-> $past(rx_wr_valid)) else $error("pool irq unprompted");
  a_timer_stop: assert property (@(posedge clk) disable iff (!resetn)
    !run_q |=> !timer_irq) else $error("timer irq while stopped");
  a_syn_idle: assert property (@(posedge clk) disable iff (!resetn)
    tx_q == bsc_pkg::BSC_TX_IDLE |-> tx_out) else $error("idle not marking");
endmodule // bsc_top

// ==== bsc_top_tb.sv ====
// Self-checking bench for the sync channel block: registers, timer, fill, DMA, receive.
// Assumes the station model on the receive line and a bit tick every second cycle.
`timescale 1ns/100ps
`include "bsc_regs.svh"
module bsc_top_tb;
  logic       clk, resetn, reg_write, reg_read, rx_in, rx_bit_tick;
  logic       tx_bit_tick = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rx_wr_data, rv;
  logic       tx_out, tx_busy, rts_out, rx_wr_valid, timer_irq, dma_tx_req;
  logic       end_char_detected_irq, receive_pool_full_irq, parity_error_irq;
  int         num_errors, tests_run, cyc, tmr_n, tmr_at, ec_n, pf_n, pe_n, dma_n, zero_n;
  logic [7:0] rxq[$];

  bsc_top #(.K_LONG(8), .K_SHORT(2)) bsc_top_i (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .tx_bit_tick(tx_bit_tick), .tx_have_data(1'b0), .tx_data_bit(1'b0),
    .tx_out(tx_out), .tx_busy(tx_busy), .rx_in(rx_in), .rx_bit_tick(rx_bit_tick),
    .rts_out(rts_out), .rx_wr_valid(rx_wr_valid), .rx_wr_data(rx_wr_data),
    .timer_irq(timer_irq), .end_char_detected_irq(end_char_detected_irq),
    .receive_pool_full_irq(receive_pool_full_irq),
    .parity_error_irq(parity_error_irq), .dma_tx_req(dma_tx_req));
  bsc_station bsc_station_i (.clk(clk), .rx_in(rx_in), .rx_bit_tick(rx_bit_tick));

  // Clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Bit tick, event counters and receive queue capture
  always @(posedge clk) begin
    tx_bit_tick <= ~tx_bit_tick;
    cyc         <= cyc + 1;
    if (timer_irq === 1'b1) begin
      tmr_n  <= tmr_n + 1;
      tmr_at <= cyc;
    end
    ec_n   <= ec_n + (end_char_detected_irq === 1'b1);
    pf_n   <= pf_n + (receive_pool_full_irq === 1'b1);
    pe_n   <= pe_n + (parity_error_irq === 1'b1);
    dma_n  <= dma_n + (dma_tx_req === 1'b1);
    zero_n <= zero_n + (tx_out === 1'b0);
    if (rx_wr_valid === 1'b1) rxq.push_back(rx_wr_data);
  end

  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", s, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Wait for the timer event count to pass n, bounded
  task automatic wait_tmr(input int n);
    for (int i = 0; i < 2000 && tmr_n == n; i++) cyc_wait(1);
    if (tmr_n == n) begin
      num_errors++;
      $display("mismatch timer wait ran out");
      wrap_up();
    end
  endtask

  // Reset values, read-back, unmapped and shared-offset access
  task automatic t_regs;
    logic [7:0] o[5] = '{`BSC_OFS_SYNC_CHAR_LOW, `BSC_OFS_SYNC_CHAR_HIGH, `BSC_OFS_TERM, `BSC_OFS_FMT, `BSC_OFS_RFC};
    logic [7:0] p[5] = '{8'hA5, 8'h5A, 8'h3C, 8'h1F, 8'h77};
    for (int i = 0; i < 5; i++) begin
      rd(o[i], rv);
      chk("reset value", rv, 16'h0000);
      wr(o[i], p[i]);
      rd(o[i], rv);
      chk("read back", rv, p[i]);
    end
    wr(8'h10, 8'hFF);
    rd(8'h10, rv);
    chk("unmapped", rv, 16'h0000);
    wr(`BSC_OFS_TRANSMIT_BYTE_COUNT_LOW, 8'h33);
    rd(`BSC_OFS_RECEIVE_BYTE_COUNT_LOW, rv);
    chk("receive count", rv, 16'h0000);
    $display("test regs done");
  endtask

  // Forced request-to-send on and off
  task automatic t_rts;
    wr(`BSC_OFS_MODE, 8'h04);
    cyc_wait(2);
    chk("rts forced", rts_out, 16'h0001);
    rd(`BSC_OFS_STAT, rv);
    chk("status rts", rv, 16'h0002);
    wr(`BSC_OFS_MODE, 8'h00);
    cyc_wait(2);
    chk("rts released", rts_out, 16'h0000);
    $display("test rts done");
  endtask

  // One-shot delays for both resolutions, then the periodic mode
  task automatic t_timer;
    logic [7:0] m[3] = '{8'h02, 8'h00, 8'h02};
    logic [7:0] t[3] = '{8'h01, 8'h01, 8'h20};
    int         e[3] = '{8, 32, 132};
    int         c0, n, a1;
    for (int i = 0; i < 3; i++) begin
      wr(`BSC_OFS_MODE, m[i]);
      wr(`BSC_OFS_TIMER, t[i]);
      c0 = cyc;
      n  = tmr_n;
      wr(`BSC_OFS_CMD, 8'h10);
      wait_tmr(n);
      chk("timer delay", 16'(tmr_at - c0 >= e[i] && tmr_at - c0 <= e[i] + 10), 16'h1);
    end
    wr(`BSC_OFS_TIMER, 8'hE2);
    n = tmr_n;
    wr(`BSC_OFS_CMD, 8'h10);
    wait_tmr(n);
    a1 = tmr_at;
    wait_tmr(n + 1);
    chk("timer period", 16'(tmr_at - a1), 16'd12);
    wr(`BSC_OFS_TIMER, 8'h00);
    $display("test timer done");
  endtask

  // Idle fill with SYN, then plain mark idle
  task automatic t_fill;
    int z;
    wr(`BSC_OFS_SYNC_CHAR_LOW, 8'h16);
    wr(`BSC_OFS_MODE, 8'h50);
    z = zero_n;
    cyc_wait(40);
    chk("fill sends syn", 16'(zero_n > z), 16'h1);
    wr(`BSC_OFS_MODE, 8'h10);
    cyc_wait(40);
    z = zero_n;
    cyc_wait(40);
    chk("mark idle", 16'(zero_n == z), 16'h1);
    $display("test fill done");
  endtask

  // DMA block lengths at the lower bound and above one byte of count
  task automatic t_dma;
    logic [11:0] x[2] = '{12'h000, 12'h905};
    int          n;
    for (int i = 0; i < 2; i++) begin
      wr(`BSC_OFS_TRANSMIT_BYTE_COUNT_LOW, x[i][7:0]);
      wr(`BSC_OFS_TRANSMIT_COUNT_HIGH, {4'h8, x[i][11:8]});
      n = dma_n;
      wr(`BSC_OFS_CMD, 8'h08);
      for (int j = 0; j < 5000; j++) begin
        cyc_wait(1);
        if (dma_n - n == x[i] + 1 && dma_tx_req !== 1'b1) break;
      end
      cyc_wait(4);
      chk("dma transfers", 16'(dma_n - n), 16'(x[i] + 1));
    end
    $display("test dma done");
  endtask

  // Hunt for SYN after stray bits, two 7-bit even-parity chars, second bad and terminal
  task automatic t_rx;
    logic [7:0] ex[4] = '{8'hC3, 8'h01, 8'hC1, 8'h81};
    int         e0, f0, p0;
    wr(`BSC_OFS_MODE, 8'h10);
    wr(`BSC_OFS_SYNC_CHAR_LOW, 8'h16);
    wr(`BSC_OFS_FMT, 8'h15);
    wr(`BSC_OFS_TERM, 8'h41);
    wr(`BSC_OFS_RFC, 8'h14);
    wr(`BSC_OFS_CMD, 8'h04);
    rxq.delete();
    e0 = ec_n;
    f0 = pf_n;
    p0 = pe_n;
    bsc_station_i.send(8'hFF, 3, 0);
    bsc_station_i.send(8'h16, 8, 1);
    bsc_station_i.send(8'hC3, 8, 0);
    bsc_station_i.send(8'hC1, 8, 2);
    cyc_wait(10);
    chk("rx bytes stored", 16'(rxq.size()), 16'd4);
    for (int i = 0; i < 4; i++) chk("rx byte", rxq[i], ex[i]);
    chk("end char event", 16'(ec_n - e0), 16'd1);
    chk("parity event", 16'(pe_n - p0), 16'd1);
    chk("pool full event", 16'(pf_n > f0), 16'h1);
    wr(`BSC_OFS_CMD, 8'h80);
    rd(`BSC_OFS_RECEIVE_BYTE_COUNT_LOW, rv);
    chk("count cleared", rv, 16'h0000);
    $display("test rx done");
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Reset, then the scenarios in turn
  initial begin
    {num_errors, tests_run, cyc, tmr_n, tmr_at, ec_n, pf_n, pe_n, dma_n, zero_n} = '0;
    resetn    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read  = 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    t_regs();
    t_rts();
    t_timer();
    t_fill();
    t_dma();
    t_rx();
    wrap_up();
  end
endmodule // bsc_top_tb
